// ===== common/smx_pkg.sv
// shared constants and types for the scan multiplexer timing core
package smx_pkg;
	// clocking
	localparam int CLK_KHZ      = 100000;           // master clock, kHz
	localparam int BIT_RATE_KHZ = 84900;            // serial output bit rate, kHz
	localparam int ACC_W        = 18;               // holds step plus largest remainder
	localparam logic [ACC_W-1:0] NCO_STEP = ACC_W'(BIT_RATE_KHZ);
	localparam logic [ACC_W-1:0] NCO_MOD  = ACC_W'(CLK_KHZ);
	// derived clocks, counted in bit periods
	localparam int REF_DIV  = 8;                    // mirror reference = bit rate / 8
	localparam int SLOW_DIV = 408;                  // corrector and supply clock
	localparam logic [1:0] REF_HALF_M1  = 2'(REF_DIV / 2 - 1);
	localparam logic [7:0] SLOW_HALF_M1 = 8'(SLOW_DIV / 2 - 1);
	// detector channels and bands
	localparam int NUM_CHAN      = 100;
	localparam int CHAN_PER_BAND = 16;
	localparam int CHAN_W        = 7;
	localparam int BAND_W        = 3;
	localparam logic [CHAN_W-1:0] WIDE_CHANS = CHAN_W'(96);   // six 16-channel bands
	localparam logic [BAND_W-1:0] NARROW_BAND = 3'h6;          // last 4-channel band
	localparam logic [BAND_W-1:0] FILL_BAND   = 3'h7;
	// words
	localparam int WORD_W = 8;
	localparam int SER_W  = 1 + BAND_W + WORD_W;  // tag, band, data
	localparam logic [WORD_W-1:0] FILL_DATA = 8'haa;
	localparam logic [3:0] SER_LAST = 4'(SER_W - 1);
	localparam int TLM_PERIOD = 16;                  // band words between telemetry slots
	localparam int DELAY_W    = 16;
	// synchroniser pin indices
	localparam int PIN_START = 0;
	localparam int PIN_MID   = 1;
	localparam int PIN_END   = 2;
	localparam int PIN_BEGIN = 3;
	localparam int PIN_STOP  = 4;
	localparam int NUM_PINS  = 5;

	// converter sample tagged with its detector channel
	typedef struct packed {
		logic [CHAN_W-1:0] chan;
		logic [WORD_W-1:0] data;
	} smx_det_t;

	// one word of the serial stream
	typedef struct packed {
		logic              is_tlm;
		logic [BAND_W-1:0] band;
		logic [WORD_W-1:0] data;
	} smx_word_t;

	// formatting window state
	typedef enum logic [1:0] {
		SMX_FMT_IDLE   = 2'b00,
		SMX_FMT_ACTIVE = 2'b01
	} smx_fmt_t;
endpackage

// ===== core/smx_buf2.sv
// two-entry valid/ready buffer
`timescale 1ns/1ps
module smx_buf2 #(
	parameter int W = 8
) (
	// clock and control
	input  wire logic         i_mclk,
	input  wire logic         i_rst,
	input  wire logic         i_ce,
	// fill side
	input  wire logic [W-1:0] i_in_data,
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	// drain side
	output logic [W-1:0]      o_out_data,
	output logic              o_out_valid,
	input  wire logic         i_out_ready
);
	logic [W-1:0] mem_reg [2];   // two storage slots
	logic         wr_ptr_reg;    // next slot to fill
	logic         rd_ptr_reg;    // oldest slot
	logic [1:0]   count_reg;     // words held
	logic [1:0]   count_next;
	logic         push;
	logic         pop;

	if (W < 1)
	begin : g_bad_w
		$error("smx_buf2: width must be at least one");
	end

	// handshake terms
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;
	assign o_out_valid = (count_reg != 2'h0);
	assign o_out_data  = mem_reg[rd_ptr_reg];

	// occupancy after this cycle
	always_comb
	begin
		count_next = count_reg;
		if (push & ~pop)
			count_next = count_reg + 2'h1;
		else if (pop & ~push)
			count_next = count_reg - 2'h1;
	end

	// storage and pointers
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end
		else if (i_ce)
		begin
			if (push)
			begin
				mem_reg[wr_ptr_reg] <= i_in_data;
				wr_ptr_reg          <= ~wr_ptr_reg;
			end
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			count_reg <= count_next;
		end
	end

	// registered ready: low only while both slots are full
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			o_in_ready <= 1'b1;
		else if (i_ce)
			o_in_ready <= (count_next != 2'h2);
	end
endmodule // smx_buf2

// ===== core/smx_delay.sv
// programmable one-shot delay counter
`timescale 1ns/1ps
module smx_delay #(
	parameter int CNT_W = 16
) (
	// clock and control
	input  wire logic             i_mclk,
	input  wire logic             i_rst,
	input  wire logic             i_ce,
	// trigger and length
	input  wire logic             i_start,
	input  wire logic [CNT_W-1:0] i_load,
	// delayed pulse
	output logic                  o_fire
);
	logic [CNT_W-1:0] cnt_reg;   // cycles still to wait
	logic             busy_reg;  // counting in progress

	if (CNT_W < 1)
	begin : g_bad_w
		$error("smx_delay: counter width must be at least one");
	end

	// load on trigger, count down, fire once at zero; a new trigger restarts
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			cnt_reg  <= '0;
			busy_reg <= 1'b0;
			o_fire   <= 1'b0;
		end
		else if (i_ce)
		begin
			o_fire <= 1'b0;
			if (i_start)
			begin
				cnt_reg  <= i_load;
				busy_reg <= 1'b1;
			end
			else if (busy_reg)
			begin
				if (cnt_reg == '0)
				begin
					o_fire   <= 1'b1;
					busy_reg <= 1'b0;
				end
				else
					cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
endmodule // smx_delay

// ===== core/smx_core.sv
// scan multiplexer timing, interleaving and serial formatting core
`timescale 1ns/1ps
//
// Operation
// - accept 100 channels, merge each band's channels
// - interleave band words with telemetry words serially
// - serial output runs at 84.9 Mbps
// - scan pulses drive filter shutter, restore syncs
// - drive 10.61 MHz reference to mirror
// - bit rate over 408 clock to corrector
// - same 208.1 kHz clock to power supply
// - buffer line stop, forward to corrector
// - delayed line stop syncs calibrator shutter
module smx_core
	import smx_pkg::*;
#(
	parameter int N_CHAN  = smx_pkg::NUM_CHAN,
	parameter int TLM_GAP = smx_pkg::TLM_PERIOD
) (
	// clock and control
	input  wire logic                      i_mclk,
	input  wire logic                      i_rst,
	input  wire logic                      i_ce,
	// scan monitor and mirror electronics pins
	input  wire logic                      i_scan_start,
	input  wire logic                      i_scan_mid,
	input  wire logic                      i_scan_end,
	input  wire logic                      i_fmt_begin,
	input  wire logic                      i_line_stop,
	// digitised detector samples
	input  wire smx_pkg::smx_det_t         i_det,
	input  wire logic                      i_det_valid,
	output logic                           o_det_ready,
	// telemetry words
	input  wire logic [smx_pkg::WORD_W-1:0] i_tlm_data,
	input  wire logic                      i_tlm_valid,
	output logic                           o_tlm_ready,
	// calibrator shutter delay, master clock cycles
	input  wire logic [smx_pkg::DELAY_W-1:0] i_cal_delay,
	// serial stream
	output logic                           o_ser_data,
	output logic                           o_ser_strobe,
	output logic                           o_word_sync,
	output logic                           o_formatting,
	// clocks to other units
	output logic                           o_mirror_ref_clk,
	output logic                           o_corrector_clk,
	output logic                           o_psu_clk,
	// sync pulses
	output logic                           o_corrector_sync,
	output logic                           o_cal_shutter_sync,
	output logic                           o_filter_shutter_sync,
	output logic                           o_dc_restore_sync
);
	import smx_pkg::*;

	// elaboration checks
	if (N_CHAN < 1 || N_CHAN > NUM_CHAN)
	begin : g_bad_chan
		$error("smx_core: channel count outside what the band map serves");
	end
	if (TLM_GAP < 1 || TLM_GAP > 255)
	begin : g_bad_gap
		$error("smx_core: telemetry spacing must be 1 to 255");
	end

	localparam logic [CHAN_W-1:0] CHAN_LIMIT = CHAN_W'(N_CHAN);
	localparam logic [7:0]        GAP_COUNT  = 8'(TLM_GAP);

	// pin synchronisers
	logic [NUM_PINS-1:0] pin_raw;     // raw pin levels
	logic [NUM_PINS-1:0] sync1_reg;   // first stage, read only by second
	logic [NUM_PINS-1:0] sync2_reg;   // second stage
	logic [NUM_PINS-1:0] sync3_reg;   // third stage
	logic [NUM_PINS-1:0] level_reg;   // accepted level
	logic [NUM_PINS-1:0] rise_reg;    // one-cycle rising edge

	// bit clock
	logic [ACC_W-1:0] acc_reg;        // phase accumulator
	logic [ACC_W-1:0] acc_sum;
	logic             bit_en;         // one bit period elapsed
	logic [1:0]       ref_cnt_reg;    // mirror reference half-period count
	logic [7:0]       slow_cnt_reg;   // slow clock half-period count

	// formatting window
	smx_fmt_t         fmt_reg;

	// data path
	smx_det_t         buf_out;        // oldest buffered sample
	logic             buf_valid;
	logic             buf_pop;
	logic [WORD_W-1:0] tlm_hold_reg;  // held telemetry word
	logic             tlm_full_reg;
	logic             tlm_take;
	logic [7:0]       slot_cnt_reg;   // band words since last telemetry
	smx_word_t        word_next;      // word chosen at a boundary
	logic [SER_W-1:0] shift_reg;      // serialiser shift register
	logic [3:0]       bit_cnt_reg;    // bits still to send of this word
	logic             word_load;      // boundary and bit period together
	logic             cal_fire;

	assign pin_raw = {i_line_stop, i_fmt_begin, i_scan_end, i_scan_mid, i_scan_start};

	// three-stage sync per pin; a level counts once stages two and three agree
	for (genvar p = 0; p < NUM_PINS; p++)
	begin : g_pin
		always_ff @(posedge i_mclk)
		begin
			if (i_rst)
			begin
				sync1_reg[p] <= 1'b0;
				sync2_reg[p] <= 1'b0;
				sync3_reg[p] <= 1'b0;
				level_reg[p] <= 1'b0;
				rise_reg[p]  <= 1'b0;
			end
			else if (i_ce)
			begin
				sync1_reg[p] <= pin_raw[p];
				sync2_reg[p] <= sync1_reg[p];
				sync3_reg[p] <= sync2_reg[p];
				// edge only on an agreed change
				rise_reg[p]  <= (sync2_reg[p] == sync3_reg[p]) & sync3_reg[p] & ~level_reg[p];
				if (sync2_reg[p] == sync3_reg[p])
					level_reg[p] <= sync3_reg[p];
			end
		end
	end

	// fractional accumulator: one bit period per 84.9 of each 100 clocks
	assign acc_sum = acc_reg + NCO_STEP;
	assign bit_en  = (acc_sum >= NCO_MOD);

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			acc_reg <= '0;
		else if (i_ce)
			acc_reg <= bit_en ? (acc_sum - NCO_MOD) : acc_sum;
	end

	// mirror reference: toggles every four bit periods
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			ref_cnt_reg      <= 2'h0;
			o_mirror_ref_clk <= 1'b0;
		end
		else if (i_ce && bit_en)
		begin
			if (ref_cnt_reg == REF_HALF_M1)
			begin
				ref_cnt_reg      <= 2'h0;
				o_mirror_ref_clk <= ~o_mirror_ref_clk;
			end
			else
				ref_cnt_reg <= ref_cnt_reg + 2'h1;
		end
	end

	// slow clock: toggles every 204 bit periods, same edge for both users
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			slow_cnt_reg    <= 8'h00;
			o_corrector_clk <= 1'b0;
			o_psu_clk       <= 1'b0;
		end
		else if (i_ce && bit_en)
		begin
			if (slow_cnt_reg == SLOW_HALF_M1)
			begin
				slow_cnt_reg    <= 8'h00;
				o_corrector_clk <= ~o_corrector_clk;
				o_psu_clk       <= ~o_psu_clk;
			end
			else
				slow_cnt_reg <= slow_cnt_reg + 8'h01;
		end
	end

	// formatting window opened by begin, closed by line stop
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			fmt_reg      <= SMX_FMT_IDLE;
			o_formatting <= 1'b0;
		end
		else if (i_ce)
		begin
			unique case (fmt_reg)
				SMX_FMT_IDLE:
					if (rise_reg[PIN_BEGIN])
						fmt_reg <= SMX_FMT_ACTIVE;
				SMX_FMT_ACTIVE:
					if (rise_reg[PIN_STOP])
						fmt_reg <= SMX_FMT_IDLE;
				default:
					fmt_reg <= SMX_FMT_IDLE;
			endcase
			o_formatting <= (fmt_reg == SMX_FMT_ACTIVE);
		end
	end

	// sync pulses from scan monitor and line stop
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			o_corrector_sync      <= 1'b0;
			o_filter_shutter_sync <= 1'b0;
			o_dc_restore_sync     <= 1'b0;
			o_cal_shutter_sync    <= 1'b0;
		end
		else if (i_ce)
		begin
			o_corrector_sync      <= rise_reg[PIN_STOP];
			o_filter_shutter_sync <= rise_reg[PIN_START] | rise_reg[PIN_MID];
			o_dc_restore_sync     <= rise_reg[PIN_END];
			o_cal_shutter_sync    <= cal_fire;
		end
	end

	// calibrator shutter delay, loaded when line stop arrives
	smx_delay #(
		.CNT_W   (DELAY_W)
	) u_cal_delay (
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_start (rise_reg[PIN_STOP]),
		.i_load  (i_cal_delay),
		.o_fire  (cal_fire)
	);

	// two-entry buffer between converter and serialiser
	smx_buf2 #(
		.W           ($bits(smx_det_t))
	) u_det_buf (
		.i_mclk      (i_mclk),
		.i_rst       (i_rst),
		.i_ce        (i_ce),
		.i_in_data   (i_det),
		.i_in_valid  (i_det_valid),
		.o_in_ready  (o_det_ready),
		.o_out_data  (buf_out),
		.o_out_valid (buf_valid),
		.i_out_ready (buf_pop)
	);

	// telemetry holding register, ready from a flop
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			tlm_hold_reg <= '0;
			tlm_full_reg <= 1'b0;
			o_tlm_ready  <= 1'b1;
		end
		else if (i_ce)
		begin
			if (i_tlm_valid && o_tlm_ready)
			begin
				tlm_hold_reg <= i_tlm_data;
				tlm_full_reg <= 1'b1;
				o_tlm_ready  <= 1'b0;
			end
			else if (tlm_take)
			begin
				tlm_full_reg <= 1'b0;
				o_tlm_ready  <= 1'b1;
			end
		end
	end

	// word selection at a boundary: telemetry slot, band sample, else fill
	assign word_load = bit_en & (bit_cnt_reg == 4'h0);

	always_comb
	begin
		word_next = '{is_tlm: 1'b1, band: FILL_BAND, data: FILL_DATA};
		tlm_take  = 1'b0;
		buf_pop   = 1'b0;
		if (fmt_reg != SMX_FMT_ACTIVE)
			buf_pop = buf_valid;               // samples outside the window are dropped
		else if (buf_valid && buf_out.chan >= CHAN_LIMIT)
			buf_pop = 1'b1;                    // unknown channel discarded
		else if (word_load)
		begin
			if (tlm_full_reg && slot_cnt_reg >= GAP_COUNT)
			begin
				word_next = '{is_tlm: 1'b1, band: '0, data: tlm_hold_reg};
				tlm_take  = 1'b1;
			end
			else if (buf_valid)
			begin
				word_next.is_tlm = 1'b0;
				word_next.data   = buf_out.data;
				// all channels of a band share one band tag
				if (buf_out.chan >= WIDE_CHANS)
					word_next.band = NARROW_BAND;
				else
					word_next.band = BAND_W'(buf_out.chan / CHAN_W'(CHAN_PER_BAND));
				buf_pop = 1'b1;
			end
		end
	end

	// band words counted since the last telemetry slot
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			slot_cnt_reg <= 8'h00;
		else if (i_ce)
		begin
			if (tlm_take)
				slot_cnt_reg <= 8'h00;
			else if (word_load && !word_next.is_tlm && slot_cnt_reg != GAP_COUNT)
				slot_cnt_reg <= slot_cnt_reg + 8'h01;
		end
	end

	// serialiser, msb first, one bit per bit period
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			shift_reg    <= '0;
			bit_cnt_reg  <= 4'h0;
			o_ser_data   <= 1'b0;
			o_ser_strobe <= 1'b0;
			o_word_sync  <= 1'b0;
		end
		else if (i_ce)
		begin
			o_ser_strobe <= bit_en;
			o_word_sync  <= word_load;
			if (word_load)
			begin
				o_ser_data  <= word_next[SER_W-1];
				shift_reg   <= {word_next[SER_W-2:0], 1'b0};
				bit_cnt_reg <= SER_LAST;
			end
			else if (bit_en)
			begin
				o_ser_data  <= shift_reg[SER_W-1];
				shift_reg   <= {shift_reg[SER_W-2:0], 1'b0};
				bit_cnt_reg <= bit_cnt_reg - 4'h1;
			end
		end
	end
endmodule // smx_core

// ===== testbench/smx_core_properties.sv
// concurrent checks on the scan multiplexer timing core ports
`timescale 1ns/1ps
module smx_core_properties
	import smx_pkg::*;
(
	// clock and reset
	input wire logic               i_mclk,
	input wire logic               i_rst,
	// scan pins and delay
	input wire logic               i_scan_start,
	input wire logic               i_scan_mid,
	input wire logic               i_scan_end,
	input wire logic               i_line_stop,
	input wire logic [DELAY_W-1:0] i_cal_delay,
	// stream and clocks
	input wire logic               o_ser_strobe,
	input wire logic               o_word_sync,
	input wire logic               o_mirror_ref_clk,
	input wire logic               o_corrector_clk,
	input wire logic               o_psu_clk,
	// sync pulses
	input wire logic               o_corrector_sync,
	input wire logic               o_cal_shutter_sync,
	input wire logic               o_filter_shutter_sync,
	input wire logic               o_dc_restore_sync
);
	logic        slow_q, ref_q;              // clock levels one cycle back
	logic [2:0]  seen_reg;                   // first interval already passed
	logic [8:0]  slow_reg, ref_reg, wrd_reg; // strobes since last edge or word
	logic [16:0] cal_reg;                    // cycles since corrector sync
	wire         slow_t = o_corrector_clk ^ slow_q;
	wire         ref_t = o_mirror_ref_clk ^ ref_q;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// strobe counts between clock edges and word marks
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			{slow_q, ref_q, seen_reg} <= '0;
			{slow_reg, ref_reg, wrd_reg} <= '0;
		end
		else
		begin
			slow_q <= o_corrector_clk;
			ref_q <= o_mirror_ref_clk;
			seen_reg <= seen_reg | {o_word_sync, ref_t, slow_t};
			slow_reg <= slow_t ? 9'h0 : slow_reg + 9'(o_ser_strobe);
			ref_reg <= ref_t ? 9'h0 : ref_reg + 9'(o_ser_strobe);
			wrd_reg <= o_word_sync ? 9'h0 : wrd_reg + 9'(o_ser_strobe);
		end
	end
	// cycles elapsed since the last corrector sync
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			cal_reg <= '0;
		else
			cal_reg <= o_corrector_sync ? 17'h1 : cal_reg + 17'h1;
	end
	a_stop_forward: assert property ($rose(i_line_stop) |-> ##[4:6] o_corrector_sync)
		else $error("corrector sync missing after line stop");
	a_cal_delay: assert property (o_cal_shutter_sync |-> cal_reg == 17'(i_cal_delay) + 17'h2)
		else $error("calibrator sync at wrong distance");
	a_filter_sync: assert property ($rose(i_scan_start) || $rose(i_scan_mid)
		|-> ##[4:6] o_filter_shutter_sync)
		else $error("filter shutter sync missing");
	a_restore_sync: assert property ($rose(i_scan_end) |-> ##[4:6] o_dc_restore_sync)
		else $error("dc restore sync missing");
	a_psu_match: assert property (o_psu_clk == o_corrector_clk)
		else $error("supply clock differs from corrector clock");
	a_slow_period: assert property (slow_t && seen_reg[0]
		|-> slow_reg + 9'(o_ser_strobe) == 9'hcc)
		else $error("corrector clock half period wrong");
	a_ref_period: assert property (ref_t && seen_reg[1]
		|-> ref_reg + 9'(o_ser_strobe) == 9'h4)
		else $error("mirror reference half period wrong");
	a_word_msb: assert property (o_word_sync |-> o_ser_strobe)
		else $error("word mark without bit strobe");
	a_word_length: assert property (o_word_sync && seen_reg[2]
		|-> wrd_reg + 9'(o_ser_strobe) == 9'hc)
		else $error("word length wrong");
	c_stop: cover property (o_corrector_sync);
	c_cal: cover property (o_cal_shutter_sync);
	c_filter: cover property (o_filter_shutter_sync);
	c_restore: cover property (o_dc_restore_sync);
endmodule // smx_core_properties

bind smx_core smx_core_properties chk_u (.i_mclk, .i_rst, .i_scan_start, .i_scan_mid,
	.i_scan_end, .i_line_stop, .i_cal_delay, .o_ser_strobe, .o_word_sync,
	.o_mirror_ref_clk, .o_corrector_clk, .o_psu_clk, .o_corrector_sync,
	.o_cal_shutter_sync, .o_filter_shutter_sync, .o_dc_restore_sync);

// ===== testbench/smx_partner.sv
// behavioural scan monitor and mirror electronics pins
`timescale 1ns/1ps
module smx_partner
	import smx_pkg::*;
(
	// clock
	input  wire logic i_mclk,
	// scan monitor pulses and window marks
	output logic      o_scan_start,
	output logic      o_scan_mid,
	output logic      o_scan_end,
	output logic      o_fmt_begin,
	output logic      o_line_stop
);
	logic [NUM_PINS-1:0] pins_reg = '0; // pin levels, low at rest
	assign {o_line_stop, o_fmt_begin, o_scan_end, o_scan_mid, o_scan_start} = pins_reg;
	// one pin high for four cycles, then a quiet cycle
	task automatic pulse(input int p);
		pins_reg[p] <= 1'b1;
		repeat (4) @(posedge i_mclk);
		pins_reg[p] <= 1'b0;
		@(posedge i_mclk);
	endtask
	// open the window, then mark start, middle and end of the line
	task automatic open_line(input int half);
		pulse(PIN_BEGIN);
		pulse(PIN_START);
		repeat (half) @(posedge i_mclk);
		pulse(PIN_MID);
		repeat (half) @(posedge i_mclk);
		pulse(PIN_END);
	endtask
endmodule // smx_partner

// ===== testbench/test_scan_mux_timing.sv
// self-checking bench for the scan multiplexer timing core
`timescale 1ns/1ps
module test_scan_mux_timing;
	import smx_pkg::*;
	// design pins
	logic i_mclk, i_rst, i_det_valid, i_tlm_valid, o_det_ready, o_tlm_ready;
	logic i_scan_start, i_scan_mid, i_scan_end, i_fmt_begin, i_line_stop;
	logic o_ser_data, o_ser_strobe, o_word_sync, o_formatting, o_mirror_ref_clk;
	logic o_corrector_clk, o_psu_clk, o_corrector_sync, o_cal_shutter_sync;
	logic o_filter_shutter_sync, o_dc_restore_sync;
	smx_det_t           i_det;
	logic [WORD_W-1:0]  i_tlm_data;
	logic [DELAY_W-1:0] i_cal_delay;
	// bench state
	int          n_mismatch = 0, check_count = 0, cyc = 0, nbits = 99, nstrb = 0, n0;
	logic [31:0] seed = 32'h04063e64; // xorshift state
	logic        saw_full = 1'b0;      // detector buffer refused once
	logic [CHAN_W-1:0] corner [8] = '{7'h0, 7'hf, 7'h10, 7'h5f, 7'h60, 7'h63, 7'h64, 7'h7f};
	smx_word_t   band_q[$], tlm_q[$], rx;
	// clock
	initial
	begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	smx_core dut_u (.i_mclk, .i_rst, .i_ce(1'b1), .i_scan_start, .i_scan_mid, .i_scan_end,
		.i_fmt_begin, .i_line_stop, .i_det, .i_det_valid, .o_det_ready, .i_tlm_data,
		.i_tlm_valid, .o_tlm_ready, .i_cal_delay, .o_ser_data, .o_ser_strobe, .o_word_sync,
		.o_formatting, .o_mirror_ref_clk, .o_corrector_clk, .o_psu_clk, .o_corrector_sync,
		.o_cal_shutter_sync, .o_filter_shutter_sync, .o_dc_restore_sync);
	smx_partner p_u (.i_mclk, .o_scan_start(i_scan_start), .o_scan_mid(i_scan_mid),
		.o_scan_end(i_scan_end), .o_fmt_begin(i_fmt_begin), .o_line_stop(i_line_stop));
	// next pseudo-random value
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// compare one result
	task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	// verdict and end of run
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one detector sample, held until taken
	task automatic send_det(input logic [CHAN_W-1:0] c, input logic [WORD_W-1:0] d);
		i_det <= '{chan: c, data: d};
		i_det_valid <= 1'b1;
		@(posedge i_mclk);
		while (o_det_ready !== 1'b1) @(posedge i_mclk);
		if (c < CHAN_W'(NUM_CHAN))
			band_q.push_back({1'b0, (c < WIDE_CHANS) ? BAND_W'(c / 16) : NARROW_BAND, d});
	endtask
	// one telemetry word, held until taken
	task automatic send_tlm(input logic [WORD_W-1:0] d);
		i_tlm_data <= d;
		i_tlm_valid <= 1'b1;
		@(posedge i_mclk);
		while (o_tlm_ready !== 1'b1) @(posedge i_mclk);
		tlm_q.push_back({1'b1, 3'h0, d});
	endtask
	// deserialise the stream and check each finished word
	always @(posedge i_mclk)
	begin
		cyc++;
		if (o_det_ready === 1'b0)
			saw_full = 1'b1;
		if (o_ser_strobe === 1'b1)
		begin
			rx = {rx[SER_W-2:0], o_ser_data};
			nstrb++;
			nbits = (o_word_sync === 1'b1) ? 1 : nbits + 1;
			if (nbits == SER_W && rx.is_tlm && rx.band == FILL_BAND)
				cmp(32'(FILL_DATA), 32'(rx.data));
			else if (nbits == SER_W && rx.is_tlm)
				cmp(tlm_q.size() ? 32'(tlm_q.pop_front()) : 32'hx, 32'(rx));
			else if (nbits == SER_W)
				cmp(band_q.size() ? 32'(band_q.pop_front()) : 32'hx, 32'(rx));
		end
		if (cyc == 60000)
		begin
			n_mismatch++;
			end_of_test();
		end
	end
	// main sequence
	initial
	begin
		i_rst = 1'b1;
		i_det = '0;
		i_det_valid = 1'b0;
		i_tlm_data = '0;
		i_tlm_valid = 1'b0;
		i_cal_delay = '0;
		repeat (16) @(posedge i_mclk);
		cmp(32'h300, {o_det_ready, o_tlm_ready, o_ser_strobe, o_word_sync, o_formatting,
			o_corrector_clk, o_mirror_ref_clk, o_corrector_sync, o_cal_shutter_sync, 1'b0});
		i_rst <= 1'b0;
		n0 = nstrb;
		repeat (1000) @(posedge i_mclk);
		cmp(1, 32'(nstrb - n0 inside {[847:851]}));
		for (int ln = 0; ln < 3; ln++)
		begin
			i_cal_delay <= (ln == 0) ? 16'h0 : 16'(xs() & 32'h1ff);
			fork
				p_u.open_line(1500);
				begin
					while (o_formatting !== 1'b1) @(posedge i_mclk);
					fork
						begin
							foreach (corner[k])
								send_det(corner[k], WORD_W'(xs()));
							// valid channels only, so both telemetry slots always come round
							repeat (32) send_det(CHAN_W'(xs() % NUM_CHAN), WORD_W'(xs()));
							i_det_valid <= 1'b0;
						end
						begin
							send_tlm(WORD_W'(xs()));
							send_tlm(WORD_W'(xs()));
							i_tlm_valid <= 1'b0;
						end
					join
				end
			join
			while (band_q.size() || tlm_q.size()) @(posedge i_mclk);
			cmp(1, 32'(o_formatting));
			p_u.pulse(PIN_STOP);
			repeat (600) @(posedge i_mclk);
			cmp(0, 32'(o_formatting));
		end
		cmp(1, 32'(saw_full));
		i_cal_delay <= 16'h100;
		p_u.pulse(PIN_STOP);
		repeat (20) @(posedge i_mclk);
		p_u.pulse(PIN_STOP);
		repeat (400) @(posedge i_mclk);
		end_of_test();
	end
endmodule // test_scan_mux_timing
